// file: rtl/clmh_defines.vh
// Purpose: constants for the CAN-linked I/O message handler
// Assumes: 8-bit registers, 5-bit register pointer
// Notes:   included by clmh_core.v
`ifndef CLMH_DEFINES_VH
`define CLMH_DEFINES_VH

// Frame layout
`define CLMH_DLC_TWO        4'h2
`define CLMH_PTR_MSB        4
`define CLMH_ERR_BIT        7
`define CLMH_BM_MSB         6
`define CLMH_BM_LSB         5

// Register pointers
`define CLMH_PTR_LOW_STAT   5'h00
`define CLMH_PTR_RISE_EN    5'h01
`define CLMH_PTR_FALL_EN    5'h02
`define CLMH_PTR_LOW_OUT    5'h03
`define CLMH_PTR_LOW_DIR    5'h04
`define CLMH_PTR_HIGH_STAT  5'h05
`define CLMH_PTR_HIGH_OUT   5'h06
`define CLMH_PTR_HIGH_DIR   5'h07
`define CLMH_PTR_ADC_FIRST  5'h08
`define CLMH_PTR_ADC_LAST   5'h0e
`define CLMH_PTR_STAT_ALIAS 5'h0f
`define CLMH_PTR_DAC_FIRST  5'h10
`define CLMH_PTR_DAC_LAST   5'h13
`define CLMH_PTR_AOUT_CTL   5'h1c
`define CLMH_PTR_CMP_CTL    5'h1e
`define CLMH_PTR_CONFIG     5'h1f

// Reset values
`define CLMH_RST_EDGE       8'h00
`define CLMH_RST_OUT        8'hff
`define CLMH_RST_DIR        8'h00
`define CLMH_RST_ZERO       8'h00

// Bus modes and configuration fields
`define CLMH_BM_DUAL        2'h0
`define CLMH_BM_RX0         2'h1
`define CLMH_BM_RX1         2'h2
`define CLMH_CFG_WDOG_BIT   0
`define CLMH_MODE_CNT_MAX   2'h3

`endif

// file: rtl/clmh_core.v
// Purpose: frame interpreter and register block of a CAN-linked I/O node
// Assumes: CAN controller delivers checked frames; analog converter external
// Notes:   one frame handled at a time, replies pass through a tx handshake
//
// What this block does
// - Bus-mode change procedure runs only while the change request flag is set.
// - Count mode changes; no frame in any mode sets the watchdog expired flag.
// - Pick next mode from rotation setting, apply it and pulse the change done flag in the same cycle.
// - Pointer 0x00 reads pins 0-7, 0x05 pins 8-13; both read only.
// - Pointers 0x01 and 0x02 hold rising and falling edge enables per pin.
// - Pointer 0x03 is low port output data, 0x04 low port direction.
// - Pointer 0x06 is high port output data, 0x07 high port direction.
// - Pointers 0x08 to 0x0e read analog result of pins 0 to 6.
// - Pointer 0x0f is a read-only alias of the low port status.
// - 0x10-0x13 analog level, 0x1c analog control, 0x1e comparator, 0x1f config.
// - Every frame carries exactly two data bytes.
// - First byte: pointer in bits 4-0, system info above; second byte is data.
// - Error bit 0 when error active, 1 if passive since the last sent frame.
// - Bus mode field: 0 dual, 1 single rx0, 2 single rx1, never 3.
// - Status frame after init, on enabled edge on pins 0-7, and on wake-up.
// - Read frame samples pins or analog input, stores it, replies with value.
// - Write frame stores data, applies it, replies with resulting contents.
// - Even identifier transmits, odd receives; global id only in memory mode.
// - Prescaler is latched from the identifier pins at init; identifiers follow the pins live.
// - Frames whose length code is not two are discarded.
// - A remote frame on the receive id gets a low port status reply.
`timescale 1ns/1ps
`include "clmh_defines.vh"

module clmh_core (
   // Clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // Received frame from CAN controller
   input  wire        rx_valid_i,
   input  wire [10:0] rx_id_i,
   input  wire [3:0]  rx_dlc_i,
   input  wire        rx_remote_i,
   input  wire [7:0]  rx_byte0_i,
   input  wire [7:0]  rx_byte1_i,
   input  wire        global_id_en_i,
   input  wire [10:0] global_id_i,
   // Transmit frame to CAN controller
   output wire        tx_valid_o,
   input  wire        tx_ready_i,
   output reg  [10:0] tx_id_o,
   output wire [3:0]  tx_dlc_o,
   output reg  [7:0]  tx_byte0_o,
   output reg  [7:0]  tx_byte1_o,
   // Controller and power state
   input  wire        error_passive_i,
   input  wire        init_done_i,
   input  wire        wake_i,
   input  wire        bus_change_request_i,
   input  wire [1:0]  bus_rotation_i,
   // Identifier pins
   input  wire [3:0]  id_pins_i,
   output reg  [3:0]  prescaler_o,
   // Port pins
   input  wire [7:0]  low_port_pins_i,
   input  wire [5:0]  high_port_pins_i,
   output wire [7:0]  port_low_output_o,
   output wire [7:0]  port_low_direction_o,
   output wire [5:0]  port_high_output_o,
   output wire [5:0]  port_high_direction_o,
   // Analog converter
   output reg         adc_start_o,
   output reg  [2:0]  adc_channel_o,
   input  wire        adc_done_i,
   input  wire [7:0]  adc_result_i,
   // Analog, comparator and configuration outputs
   output wire [31:0] analog_output_level_o,
   output wire [7:0]  analog_output_control_o,
   output wire [7:0]  comparator_control_o,
   output wire [7:0]  node_configuration_o,
   // Bus mode and watchdog
   output wire [1:0]  bus_mode_field_o,
   output wire        bus_change_done_o,
   output wire        watchdog_expired_flag_o
);

   // One-hot interpreter states
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_ADC  = 4'h2;
   localparam [3:0] ST_SEND = 4'h4;
   localparam [3:0] ST_BUS  = 4'h8;

   reg  [3:0]  state_r;
   reg  [7:0]  rise_en_r;
   reg  [7:0]  fall_en_r;
   reg  [7:0]  low_out_r;
   reg  [7:0]  low_dir_r;
   reg  [7:0]  high_out_r;
   reg  [7:0]  high_dir_r;
   reg  [7:0]  low_stat_r;
   reg  [7:0]  high_stat_r;
   reg  [7:0]  adc_r;
   reg  [7:0]  dac_r [0:3];
   reg  [7:0]  aout_ctl_r;
   reg  [7:0]  cmp_ctl_r;
   reg  [7:0]  config_r;
   reg  [1:0]  bus_mode_r;
   reg  [1:0]  mode_cnt_r;
   reg         rx_seen_r;
   reg         wdog_r;
   reg         passive_seen_r;
   reg  [7:0]  pins_prev_r;
   reg         status_pend_r;
   reg         init_seen_r;
   reg  [6:0]  id_base_r;
   reg         bus_done_r;
   wire [10:0] own_tx_id;
   wire [10:0] own_rx_id;
   wire        id_hit;
   wire        frame_ok;
   wire [4:0]  ptr;
   wire        ptr_adc;
   wire        ptr_dac;
   wire        ptr_ro;
   wire        ptr_rw;
   wire [7:0]  edge_hit;
   wire [7:0]  sys_info;

   // Identifier pair: fixed upper bits, pins select node; even tx, odd rx
   assign own_tx_id = {id_base_r, id_pins_i[3:0]} & 11'h7fe;
   assign own_rx_id = own_tx_id | 11'h001;
   // Global id only honoured when memory configuration enables it
   assign id_hit = (rx_id_i == own_rx_id) || (global_id_en_i && rx_id_i == global_id_i);
   assign frame_ok = rx_valid_i && id_hit && (rx_dlc_i == `CLMH_DLC_TWO);

   // Pointer decode
   assign ptr     = rx_byte0_i[`CLMH_PTR_MSB:0];
   assign ptr_adc = (ptr >= `CLMH_PTR_ADC_FIRST) && (ptr <= `CLMH_PTR_ADC_LAST);
   assign ptr_dac = (ptr >= `CLMH_PTR_DAC_FIRST) && (ptr <= `CLMH_PTR_DAC_LAST);
   assign ptr_ro  = (ptr == `CLMH_PTR_LOW_STAT) || (ptr == `CLMH_PTR_HIGH_STAT) ||
                    (ptr == `CLMH_PTR_STAT_ALIAS) || ptr_adc;
   assign ptr_rw  = (ptr == `CLMH_PTR_RISE_EN) || (ptr == `CLMH_PTR_FALL_EN) ||
                    (ptr == `CLMH_PTR_LOW_OUT) || (ptr == `CLMH_PTR_LOW_DIR) ||
                    (ptr == `CLMH_PTR_HIGH_OUT) || (ptr == `CLMH_PTR_HIGH_DIR) || ptr_dac ||
                    (ptr == `CLMH_PTR_AOUT_CTL) || (ptr == `CLMH_PTR_CMP_CTL) ||
                    (ptr == `CLMH_PTR_CONFIG);

   // Enabled edges on the low port pins
   assign edge_hit = (low_port_pins_i & ~pins_prev_r & rise_en_r) |
                     (~low_port_pins_i & pins_prev_r & fall_en_r);

   // System info bits: error status and current bus mode
   assign sys_info = {passive_seen_r, bus_mode_r, 5'h00};

   // Register outputs
   assign port_low_output_o       = low_out_r;
   assign port_low_direction_o    = low_dir_r;
   assign port_high_output_o      = high_out_r[5:0];
   assign port_high_direction_o   = high_dir_r[5:0];
   assign analog_output_level_o   = {dac_r[3], dac_r[2], dac_r[1], dac_r[0]};
   assign analog_output_control_o = aout_ctl_r;
   assign comparator_control_o    = cmp_ctl_r;
   assign node_configuration_o    = config_r;
   assign bus_mode_field_o        = bus_mode_r;
   assign bus_change_done_o       = bus_done_r;
   // Flag only shown when watchdog is enabled in configuration; the count runs regardless
   assign watchdog_expired_flag_o = wdog_r & config_r[`CLMH_CFG_WDOG_BIT];
   assign tx_valid_o              = state_r[2];
   assign tx_dlc_o                = `CLMH_DLC_TWO;

   // Fixed upper identifier bits; arbitrary neutral value
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         id_base_r   <= 7'h40;
         prescaler_o <= 4'h0;
         init_seen_r <= 1'b0;
      end else if (init_done_i && !init_seen_r) begin
         // Pins are latched once at end of init, not from frames
         prescaler_o <= id_pins_i;
         init_seen_r <= 1'b1;
      end
   end

   // Edge history and status-frame request; a new cause wins over the clear
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pins_prev_r   <= 8'h00;
         status_pend_r <= 1'b0;
      end else begin
         pins_prev_r <= low_port_pins_i;
         if ((init_done_i && !init_seen_r) || wake_i || (|edge_hit))
            status_pend_r <= 1'b1;
         else if (state_r[0] && !frame_ok && !bus_change_request_i)
            status_pend_r <= 1'b0;
      end
   end

   // Error-passive memory, cleared once a sent frame has carried it; new entry wins
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         passive_seen_r <= 1'b0;
      end else if (error_passive_i) begin
         passive_seen_r <= 1'b1;
      end else if (tx_valid_o && tx_ready_i && tx_byte0_o[`CLMH_ERR_BIT]) begin
         passive_seen_r <= 1'b0;
      end
   end

   // Interpreter: frame decode, register update, reply, bus mode change
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r     <= ST_IDLE;
         rise_en_r   <= `CLMH_RST_EDGE;
         fall_en_r   <= `CLMH_RST_EDGE;
         low_out_r   <= `CLMH_RST_OUT;
         low_dir_r   <= `CLMH_RST_DIR;
         high_out_r  <= `CLMH_RST_OUT;
         high_dir_r  <= `CLMH_RST_DIR;
         low_stat_r  <= `CLMH_RST_ZERO;
         high_stat_r <= `CLMH_RST_ZERO;
         adc_r       <= `CLMH_RST_ZERO;
         dac_r[0]    <= `CLMH_RST_ZERO;
         dac_r[1]    <= `CLMH_RST_ZERO;
         dac_r[2]    <= `CLMH_RST_ZERO;
         dac_r[3]    <= `CLMH_RST_ZERO;
         aout_ctl_r  <= `CLMH_RST_ZERO;
         cmp_ctl_r   <= `CLMH_RST_ZERO;
         config_r    <= `CLMH_RST_ZERO;
         bus_mode_r  <= `CLMH_BM_DUAL;
         mode_cnt_r  <= 2'h0;
         rx_seen_r   <= 1'b0;
         wdog_r      <= 1'b0;
         bus_done_r  <= 1'b0;
         adc_start_o <= 1'b0;
         adc_channel_o <= 3'h0;
         tx_id_o     <= 11'h000;
         tx_byte0_o  <= 8'h00;
         tx_byte1_o  <= 8'h00;
      end else begin
         adc_start_o <= 1'b0;
         bus_done_r  <= 1'b0;
         if (frame_ok)
            rx_seen_r <= 1'b1;
         case (state_r)
            ST_IDLE: begin
               tx_id_o <= own_tx_id;
               if (bus_change_request_i) begin
                  state_r <= ST_BUS;
               end else if (frame_ok && rx_remote_i) begin
                  low_stat_r <= low_port_pins_i;
                  tx_byte0_o <= sys_info | {3'h0, `CLMH_PTR_LOW_STAT};
                  tx_byte1_o <= low_port_pins_i;
                  state_r    <= ST_SEND;
               end else if (frame_ok && ptr_adc) begin
                  adc_channel_o <= ptr[2:0];
                  adc_start_o   <= 1'b1;
                  tx_byte0_o    <= sys_info | {3'h0, ptr};
                  state_r       <= ST_ADC;
               end else if (frame_ok && ptr_ro) begin
                  // Sample live pins into the status register and reply
                  tx_byte0_o <= sys_info | {3'h0, ptr};
                  if (ptr == `CLMH_PTR_HIGH_STAT) begin
                     high_stat_r <= {2'h0, high_port_pins_i};
                     tx_byte1_o  <= {2'h0, high_port_pins_i};
                  end else begin
                     low_stat_r <= low_port_pins_i;
                     tx_byte1_o <= low_port_pins_i;
                  end
                  state_r <= ST_SEND;
               end else if (frame_ok && ptr_rw) begin
                  // Store then echo the resulting contents
                  tx_byte0_o <= sys_info | {3'h0, ptr};
                  tx_byte1_o <= ptr_dac ? rx_byte1_i :
                                (ptr == `CLMH_PTR_HIGH_OUT || ptr == `CLMH_PTR_HIGH_DIR) ?
                                {2'h0, rx_byte1_i[5:0]} : rx_byte1_i;
                  if (ptr == `CLMH_PTR_RISE_EN)
                     rise_en_r <= rx_byte1_i;
                  else if (ptr == `CLMH_PTR_FALL_EN)
                     fall_en_r <= rx_byte1_i;
                  else if (ptr == `CLMH_PTR_LOW_OUT)
                     low_out_r <= rx_byte1_i;
                  else if (ptr == `CLMH_PTR_LOW_DIR)
                     low_dir_r <= rx_byte1_i;
                  else if (ptr == `CLMH_PTR_HIGH_OUT)
                     high_out_r <= {2'h0, rx_byte1_i[5:0]};
                  else if (ptr == `CLMH_PTR_HIGH_DIR)
                     high_dir_r <= {2'h0, rx_byte1_i[5:0]};
                  else if (ptr_dac)
                     dac_r[ptr[1:0]] <= rx_byte1_i;
                  else if (ptr == `CLMH_PTR_AOUT_CTL)
                     aout_ctl_r <= rx_byte1_i;
                  else if (ptr == `CLMH_PTR_CMP_CTL)
                     cmp_ctl_r <= rx_byte1_i;
                  else
                     config_r <= rx_byte1_i;
                  state_r <= ST_SEND;
               end else if (status_pend_r) begin
                  tx_byte0_o <= sys_info | {3'h0, `CLMH_PTR_LOW_STAT};
                  tx_byte1_o <= low_port_pins_i;
                  state_r    <= ST_SEND;
               end
               // Unknown pointer or foreign frame falls through untouched
            end
            ST_ADC: begin
               if (adc_done_i) begin
                  adc_r      <= adc_result_i;
                  tx_byte1_o <= adc_result_i;
                  state_r    <= ST_SEND;
               end
            end
            ST_SEND: begin
               // Reply stands untouched until taken; a passive entry
               // seen while waiting is kept for the next frame if this reply has error bit 0
               if (tx_ready_i)
                  state_r <= ST_IDLE;
            end
            ST_BUS: begin
               // Watchdog: a full rotation with no frame heard
               if (rx_seen_r || frame_ok) begin
                  mode_cnt_r <= 2'h0;
               end else if (mode_cnt_r == `CLMH_MODE_CNT_MAX - 2'h1) begin
                  wdog_r     <= 1'b1;
                  mode_cnt_r <= 2'h0;
               end else begin
                  mode_cnt_r <= mode_cnt_r + 2'h1;
               end
               rx_seen_r <= 1'b0;
               // Rotation 0 cycles all modes, otherwise a fixed mode; 3 is never used
               if (bus_rotation_i == 2'h0)
                  bus_mode_r <= (bus_mode_r == `CLMH_BM_RX1) ? `CLMH_BM_DUAL : bus_mode_r + 2'h1;
               else if (bus_rotation_i == 2'h3)
                  bus_mode_r <= `CLMH_BM_DUAL;
               else
                  bus_mode_r <= bus_rotation_i;
               bus_done_r <= 1'b1;
               state_r    <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

endmodule // clmh_core

// file: tb/clmh_core_assertions.sv
// Purpose: port checks for clmh_core
// Assumes: one clock, asynchronous high reset
// Notes:   attached to every clmh_core by bind
`timescale 1ns/1ps
module clmh_chk (
   // Clock and reset
   input wire        clk_i,
   input wire        rst_i,
   // Transmit side
   input wire        tx_valid_o,
   input wire        tx_ready_i,
   input wire [10:0] tx_id_o,
   input wire [3:0]  tx_dlc_o,
   input wire [7:0]  tx_byte0_o,
   input wire [7:0]  tx_byte1_o,
   // Mode, watchdog, registers, analog
   input wire [1:0]  bus_mode_field_o,
   input wire        bus_change_done_o,
   input wire        bus_change_request_i,
   input wire        watchdog_expired_flag_o,
   input wire [7:0]  node_configuration_o,
   input wire [7:0]  port_low_direction_o,
   input wire        adc_done_i,
   input wire [7:0]  adc_result_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Frame shape and contents, bus mode and watchdog rules
   AST_DLC: assert property (tx_valid_o |-> tx_dlc_o == 4'h2)
      else $error("reply length is not two");
   AST_BM_LEGAL: assert property (bus_mode_field_o != 2'h3)
      else $error("illegal bus mode");
   AST_BM_IN_FRAME: assert property (tx_valid_o |-> tx_byte0_o[6:5] == bus_mode_field_o)
      else $error("frame mode field differs from mode");
   AST_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte0_o) && $stable(tx_byte1_o))
      else $error("reply changed before acceptance");
   AST_TX_ID: assert property (tx_valid_o |-> tx_id_o[0] == 1'b0 && tx_id_o[10:4] == 7'h40)
      else $error("transmit id not even own id");
   AST_WDOG: assert property (watchdog_expired_flag_o |-> node_configuration_o[0])
      else $error("watchdog flag while disabled");
   AST_MODE_REQ: assert property ($changed(bus_mode_field_o) |-> bus_change_done_o && $past(bus_change_request_i))
      else $error("mode changed without request");
   AST_ECHO_DIR: assert property (tx_valid_o && tx_byte0_o[4:0] == 5'h04 |-> tx_byte1_o == port_low_direction_o)
      else $error("direction echo differs");
   AST_ADC_REPLY: assert property (adc_done_i |=> tx_valid_o && tx_byte1_o == $past(adc_result_i))
      else $error("analog result not replied");
   // Main scenarios
   COV_HANDSHAKE: cover property (tx_valid_o && tx_ready_i);
   COV_MODE: cover property (bus_change_done_o);
   COV_WDOG: cover property ($rose(watchdog_expired_flag_o));
endmodule // clmh_chk

bind clmh_core clmh_chk clmh_chk_i (.*);

// file: tb/clmh_master_model.sv
// Purpose: far-side master and analog converter model
// Assumes: bench sets slow_i per transfer
// Notes:   result lines carry junk outside the done pulse
`timescale 1ns/1ps
module clmh_master_model (
   // Clock and control
   input  wire        clk_i,
   input  wire        slow_i,
   // Replies from the node
   input  wire        tx_valid_o,
   input  wire [10:0] tx_id_o,
   input  wire [7:0]  tx_byte0_o,
   input  wire [7:0]  tx_byte1_o,
   output reg         tx_ready_i = 1'b0,
   output reg  [10:0] got_id = 11'h000,
   output reg  [15:0] got_data = 16'h0000,
   output reg  [15:0] got_cnt = 16'h0000,
   // Analog converter
   input  wire        adc_start_o,
   input  wire [2:0]  adc_channel_o,
   output reg         adc_done_i = 1'b0,
   output reg  [7:0]  adc_result_i = 8'h00
);
   reg [2:0] stall_r = 3'h0, conv_r = 3'h0, ch_r = 3'h0;
   // Ready late when slow, changed only after an edge
   always @(negedge clk_i) begin
      stall_r <= tx_valid_o ? stall_r + 3'h1 : 3'h0;
      tx_ready_i <= tx_valid_o && (!slow_i || stall_r == 3'h4);
   end
   // Take whole two-byte replies
   always @(posedge clk_i) begin
      if (tx_valid_o && tx_ready_i) begin
         got_id <= tx_id_o;
         got_data <= {tx_byte0_o, tx_byte1_o};
         got_cnt <= got_cnt + 16'h1;
      end
   end
   // Converter answers after three cycles, value from channel
   always @(posedge clk_i) begin
      if (adc_start_o) ch_r <= adc_channel_o;
      conv_r <= adc_start_o ? 3'h3 : (conv_r != 3'h0 ? conv_r - 3'h1 : 3'h0);
      adc_done_i <= (conv_r == 3'h1);
      adc_result_i <= (conv_r == 3'h1) ? 8'h30 + {5'h00, ch_r} : ~adc_result_i;
   end
endmodule // clmh_master_model

// file: tb/testbench.sv
// Purpose: self-checking bench for clmh_core
// Assumes: master model takes replies and runs conversions
// Notes:   data from a fixed xorshift seed
`timescale 1ns/1ps
module testbench;
   // Stimulus
   reg         clk_i = 1'b0, rst_i = 1'b1, rx_valid_i = 1'b0, rx_remote_i = 1'b0, global_id_en_i = 1'b0;
   reg         error_passive_i = 1'b0, init_done_i = 1'b0, wake_i = 1'b0, bus_change_request_i = 1'b0, slow_i = 1'b0;
   reg  [10:0] rx_id_i = 11'h000, global_id_i = 11'h7ff;
   reg  [3:0]  rx_dlc_i = 4'h2, id_pins_i = 4'h6;
   reg  [7:0]  rx_byte0_i = 8'h00, rx_byte1_i = 8'h00, low_port_pins_i = 8'h5a, d;
   reg  [5:0]  high_port_pins_i = 6'h2c;
   reg  [1:0]  bus_rotation_i = 2'h1, exp_bm = 2'h0;
   reg  [4:0]  p;
   reg  [15:0] cnt0;
   reg  [31:0] seed = 32'h2eb5;
   reg  [64:0] wr_tab = {5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h10, 5'h11, 5'h12, 5'h13, 5'h1c, 5'h1e, 5'h1f};
   reg  [7:0]  shadow [0:31];
   integer     errors = 0, n_compared = 0, i, k;
   // Design and model outputs
   wire        tx_valid_o, tx_ready_i, adc_start_o, adc_done_i, bus_change_done_o, watchdog_expired_flag_o;
   wire [10:0] tx_id_o, got_id;
   wire [3:0]  tx_dlc_o, prescaler_o;
   wire [7:0]  tx_byte0_o, tx_byte1_o, adc_result_i, port_low_output_o, port_low_direction_o;
   wire [7:0]  analog_output_control_o, comparator_control_o, node_configuration_o;
   wire [5:0]  port_high_output_o, port_high_direction_o;
   wire [2:0]  adc_channel_o;
   wire [31:0] analog_output_level_o;
   wire [1:0]  bus_mode_field_o;
   wire [15:0] got_data, got_cnt;
   wire [10:0] own_rx = {7'h40, id_pins_i[3:1], 1'b1};
   clmh_core clmh_core_i (.*);
   clmh_master_model clmh_master_model_i (.*);
   always #25 clk_i = ~clk_i;
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   // First reply byte: error active, tracked mode
   function [7:0] hb(input [4:0] ptr);
      hb = {1'b0, exp_bm, ptr};
   endfunction
   task cmp(input [15:0] got, input [15:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("errors=%0d compared=%0d", errors, n_compared);
         if (errors == 0 && n_compared > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   // Wait for one reply, or make sure none comes
   task chk_frame(input rep, input [7:0] e0, input [7:0] e1);
      begin
         k = 0;
         while (rep && got_cnt === cnt0 && k < 300) begin
            @(negedge clk_i);
            k = k + 1;
         end
         if (k == 300) begin
            errors = errors + 1;
            test_done;
         end
         if (!rep) repeat (30) @(negedge clk_i);
         cmp(got_cnt, cnt0 + {15'h0000, rep});
         if (rep) cmp({5'h00, got_id}, {5'h00, own_rx ^ 11'h001});
         if (rep) cmp(got_data, {e0, e1});
      end
   endtask
   // One master frame; lines turn to junk after the pulse
   task xfer(input [10:0] id, input [3:0] dlc, input [7:0] b0, input [7:0] b1, input rep, input [7:0] e0, input [7:0] e1);
      begin
         @(negedge clk_i);
         cnt0 = got_cnt;
         seed = xs(seed);
         slow_i = seed[0];
         rx_id_i = id;
         rx_dlc_i = dlc;
         rx_byte0_i = b0;
         rx_byte1_i = b1;
         rx_valid_i = 1'b1;
         @(negedge clk_i);
         rx_valid_i = 1'b0;
         rx_byte0_i = ~b0;
         rx_byte1_i = ~b1;
         chk_frame(rep, e0, e1);
      end
   endtask
   task chk_regs;
      begin
         cmp(port_low_output_o, shadow[3]);
         cmp(port_low_direction_o, shadow[4]);
         cmp(port_high_output_o, shadow[6] & 8'h3f);
         cmp(port_high_direction_o, shadow[7] & 8'h3f);
         cmp(analog_output_level_o[31:16], {shadow[19], shadow[18]});
         cmp(analog_output_level_o[15:0], {shadow[17], shadow[16]});
         cmp({analog_output_control_o, comparator_control_o}, {shadow[28], shadow[30]});
         cmp(node_configuration_o, shadow[31]);
      end
   endtask
   // Timer request held until the done pulse
   task bus_change(input [1:0] rot);
      begin
         @(negedge clk_i);
         bus_rotation_i = rot;
         bus_change_request_i = 1'b1;
         for (k = 0; k < 50 && bus_change_done_o !== 1'b1; k = k + 1) @(negedge clk_i);
         if (k == 50) begin
            errors = errors + 1;
            test_done;
         end
         bus_change_request_i = 1'b0;
         cmp({15'h0000, bus_change_done_o}, 16'h0001);
      end
   endtask
   initial begin
      for (i = 0; i < 32; i = i + 1) shadow[i] = 8'h00;
      shadow[3] = 8'hff;
      shadow[6] = 8'hff;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      chk_regs;
      cnt0 = got_cnt;
      init_done_i = 1'b1;
      chk_frame(1'b1, hb(5'h00), 8'h5a);
      cmp({12'h000, prescaler_o}, {12'h000, id_pins_i});
      for (i = 0; i < 13; i = i + 1) begin
         p = wr_tab[(12 - i) * 5 +: 5];
         seed = xs(seed);
         d = seed[15:8];
         shadow[p] = d;
         xfer(own_rx, 4'h2, {seed[2:0], p}, d, 1'b1, hb(p), (p == 5'h06 || p == 5'h07) ? d & 8'h3f : d);
      end
      chk_regs;
      xfer(own_rx, 4'h2, 8'h00, 8'h33, 1'b1, hb(5'h00), 8'h5a);
      xfer(own_rx, 4'h2, 8'h0f, 8'h33, 1'b1, hb(5'h0f), 8'h5a);
      xfer(own_rx, 4'h2, 8'h05, 8'h33, 1'b1, hb(5'h05), 8'h2c);
      for (i = 8; i < 15; i = i + 1) xfer(own_rx, 4'h2, i[7:0], 8'h00, 1'b1, hb(i[4:0]), 8'h30 + i[2:0]);
      // Frames that must be dropped
      xfer(own_rx, 4'h2, 8'h14, 8'h77, 1'b0, 8'h00, 8'h00);
      xfer(own_rx, 4'h2, 8'h1d, 8'h77, 1'b0, 8'h00, 8'h00);
      xfer(own_rx, 4'h3, 8'h03, 8'h77, 1'b0, 8'h00, 8'h00);
      xfer(own_rx ^ 11'h001, 4'h2, 8'h03, 8'h77, 1'b0, 8'h00, 8'h00);
      xfer(global_id_i, 4'h2, 8'h03, 8'h77, 1'b0, 8'h00, 8'h00);
      global_id_en_i = 1'b1;
      xfer(global_id_i, 4'h2, 8'h00, 8'h00, 1'b1, hb(5'h00), 8'h5a);
      global_id_en_i = 1'b0;
      chk_regs;
      rx_remote_i = 1'b1;
      xfer(own_rx, 4'h2, 8'h03, 8'h77, 1'b1, hb(5'h00), 8'h5a);
      rx_remote_i = 1'b0;
      error_passive_i = 1'b1;
      @(negedge clk_i);
      error_passive_i = 1'b0;
      xfer(own_rx, 4'h2, 8'h00, 8'h00, 1'b1, hb(5'h00) | 8'h80, 8'h5a);
      xfer(own_rx, 4'h2, 8'h00, 8'h00, 1'b1, hb(5'h00), 8'h5a);
      // Rising edge on pin 0 enabled, falling not
      xfer(own_rx, 4'h2, 8'h01, 8'h01, 1'b1, hb(5'h01), 8'h01);
      xfer(own_rx, 4'h2, 8'h02, 8'h00, 1'b1, hb(5'h02), 8'h00);
      cnt0 = got_cnt;
      low_port_pins_i = 8'h5b;
      chk_frame(1'b1, hb(5'h00), 8'h5b);
      cnt0 = got_cnt;
      low_port_pins_i = 8'h5a;
      chk_frame(1'b0, 8'h00, 8'h00);
      cnt0 = got_cnt;
      wake_i = 1'b1;
      @(negedge clk_i);
      wake_i = 1'b0;
      chk_frame(1'b1, hb(5'h00), 8'h5a);
      for (i = 1; i < 4; i = i + 1) begin
         bus_change(i[1:0]);
         exp_bm = (i == 3) ? 2'h0 : i[1:0];
         @(negedge clk_i);
         cmp(bus_mode_field_o, exp_bm);
         xfer(own_rx, 4'h2, 8'h00, 8'h00, 1'b1, hb(5'h00), 8'h5a);
      end
      xfer(own_rx, 4'h2, 8'h1f, 8'h01, 1'b1, hb(5'h1f), 8'h01);
      cmp(watchdog_expired_flag_o, 1'b0);
      // First change only clears the count left by the config frame
      for (i = 0; i < 4; i = i + 1) bus_change(2'h0);
      @(negedge clk_i);
      cmp(watchdog_expired_flag_o, 1'b1);
      cmp(bus_mode_field_o, 2'h1);
      test_done;
   end
endmodule // testbench
